// *** logic/osr_pkg.sv ***
// Package of constants for the operation status register set
package osr_pkg;

    localparam int OSR_WIDTH = 16;
    localparam int OSR_ADDR_W = 4;

    // Register select codes on the command port
    localparam logic [3:0] OSR_SEL_OP_EVENT = 4'h0;
    localparam logic [3:0] OSR_SEL_OP_COND = 4'h1;
    localparam logic [3:0] OSR_SEL_OP_ENABLE = 4'h2;
    localparam logic [3:0] OSR_SEL_OP_RISE = 4'h3;
    localparam logic [3:0] OSR_SEL_OP_FALL = 4'h4;
    localparam logic [3:0] OSR_SEL_AP_EVENT = 4'h5;
    localparam logic [3:0] OSR_SEL_AP_COND = 4'h6;
    localparam logic [3:0] OSR_SEL_AP_ENABLE = 4'h7;
    localparam logic [3:0] OSR_SEL_AP_RISE = 4'h8;
    localparam logic [3:0] OSR_SEL_AP_FALL = 4'h9;

    // Condition bit positions of the operation set
    localparam int OSR_BIT_CAL = 0;
    localparam int OSR_BIT_SWEEP = 3;
    localparam int OSR_BIT_TRIG = 5;
    localparam int OSR_BIT_SYST = 12;
    localparam int OSR_BIT_INST = 13;
    localparam int OSR_BIT_SCRIPT = 14;

    // Writable range is 0 to 32767
    localparam logic [15:0] OSR_WRITE_MASK = 16'h7FFF;

    // Reset values
    localparam logic [15:0] OSR_RST_ENABLE = 16'h0000;
    localparam logic [15:0] OSR_RST_RISE = 16'h7FFF;
    localparam logic [15:0] OSR_RST_FALL = 16'h0000;
    localparam logic [15:0] OSR_RST_ZERO = 16'h0000;

endpackage

// *** logic/osr_set_if.sv ***
// Interface between the top control and one status register set
`timescale 1ns/100ps
interface osr_set_if;
    logic [15:0] cond;
    logic [15:0] wdata;
    logic wr_enable;
    logic wr_rise;
    logic wr_fall;
    logic clr_event;
    logic [15:0] event_q;
    logic [15:0] enable_q;
    logic [15:0] rise_q;
    logic [15:0] fall_q;
    logic summary;

    modport ctrl (
        output cond, wdata, wr_enable, wr_rise, wr_fall, clr_event,
        input event_q, enable_q, rise_q, fall_q, summary
    );
    modport set (
        input cond, wdata, wr_enable, wr_rise, wr_fall, clr_event,
        output event_q, enable_q, rise_q, fall_q, summary
    );
endinterface // osr_set_if

// *** logic/osr_status_set.sv ***
// One status register set: filters, event latch, enable mask, summary
`timescale 1ns/100ps
module osr_status_set
    import osr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    osr_set_if.set s
);
    logic [15:0] prev_q;
    logic [15:0] hit;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= OSR_RST_ZERO;
        end else begin
            prev_q <= s.cond;
        end
    end

    assign hit = (s.cond & ~prev_q & s.rise_q) // RULE3
               | (~s.cond & prev_q & s.fall_q); // RULE4

    // Set wins over the clear from a read
    always_ff @(posedge clk) begin
        if (rst) begin
            s.event_q <= OSR_RST_ZERO;
        end else if (s.clr_event) begin
            s.event_q <= hit;
        end else begin
            s.event_q <= s.event_q | hit; // RULE14
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s.enable_q <= OSR_RST_ENABLE;
            s.rise_q <= OSR_RST_RISE;
            s.fall_q <= OSR_RST_FALL;
        end else begin
            if (s.wr_enable) begin
                s.enable_q <= s.wdata & OSR_WRITE_MASK; // RULE2
            end
            if (s.wr_rise) begin
                s.rise_q <= s.wdata & OSR_WRITE_MASK;
            end
            if (s.wr_fall) begin
                s.fall_q <= s.wdata & OSR_WRITE_MASK;
            end
        end
    end

    assign s.summary = |(s.event_q & s.enable_q);
endmodule // osr_status_set

// *** logic/osr_top.sv ***
// Operation status register set with nested apparatus set
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Enabled operation event bit going true raises the operation summary.
// [RULE2] All mask and status registers are 16 bits; writes span 0 to 32767.
// [RULE3] Rise filter bit set: condition 0 to 1 sets the event bit.
// [RULE4] Fall filter bit set: condition 1 to 0 sets the event bit.
// [RULE5] Operation enable, rise and fall filters read back unchanged.
// [RULE6] Operation condition bits: 0 cal, 3 sweep, 5 trig, 12 sys, 13 inst, 14 script.
// [RULE7] Script bit is true exactly while a script runs.
// [RULE8] Reading the apparatus event register returns it and clears it.
// [RULE9] Reading the apparatus condition register returns it and then clears it; the code reloads bits still true at once.
// [RULE10] Apparatus enable mask gates its events into the apparatus summary bit.
// [RULE11] Apparatus rise, fall and enable registers read back unchanged.
// [RULE12] Reading the operation event register returns it and clears it.
// [RULE13] Reading the operation condition register is non-destructive and live.
// [RULE14] Conditions sampled every clock; event bits stay set until read.
module osr_top
    import osr_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CALIBRATING_FLAG,
    input wire logic SWEEPING_FLAG,
    input wire logic TRIGGER_SUMMARY_FLAG,
    input wire logic SYSTEM_SUMMARY_FLAG,
    input wire logic SCRIPT_ACTIVE_FLAG,
    input wire logic [15:0] APPARATUS_COND,
    input wire logic [3:0] REG_SEL,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    output logic OPER_SUMMARY,
    output logic APPARATUS_SUMMARY
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [20:0] pin_s1_q;
    logic [20:0] pin_s2_q;
    logic [20:0] pin_raw;

    assign pin_raw = {SCRIPT_ACTIVE_FLAG, SYSTEM_SUMMARY_FLAG, TRIGGER_SUMMARY_FLAG,
                      SWEEPING_FLAG, CALIBRATING_FLAG, APPARATUS_COND};

    // Every clock samples the condition inputs
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pin_s1_q <= 21'h000000;
            pin_s2_q <= 21'h000000;
        end else begin
            pin_s1_q <= pin_raw; // RULE14
            pin_s2_q <= pin_s1_q;
        end
    end

    logic [15:0] ap_live;
    logic cal_s;
    logic sweep_s;
    logic trig_s;
    logic syst_s;
    logic script_s;

    assign ap_live = pin_s2_q[15:0];
    assign cal_s = pin_s2_q[16];
    assign sweep_s = pin_s2_q[17];
    assign trig_s = pin_s2_q[18];
    assign syst_s = pin_s2_q[19];
    assign script_s = pin_s2_q[20];

    ////////////////////////////////////////////////////////////////////////////
    // Register sets
    osr_set_if op_if ();
    osr_set_if ap_if ();

    osr_status_set u_op_set (
        .clk(MCLK),
        .rst(RESET),
        .s(op_if.set)
    );

    osr_status_set u_ap_set (
        .clk(MCLK),
        .rst(RESET),
        .s(ap_if.set)
    );

    logic rd_op_event;
    logic rd_ap_event;
    logic rd_ap_cond;

    assign rd_op_event = REG_RD && (REG_SEL == OSR_SEL_OP_EVENT);
    assign rd_ap_event = REG_RD && (REG_SEL == OSR_SEL_AP_EVENT);
    assign rd_ap_cond = REG_RD && (REG_SEL == OSR_SEL_AP_COND);

    always_comb begin
        op_if.cond = 16'h0000;
        op_if.cond[OSR_BIT_CAL] = cal_s; // RULE6
        op_if.cond[OSR_BIT_SWEEP] = sweep_s; // RULE6
        op_if.cond[OSR_BIT_TRIG] = trig_s; // RULE6
        op_if.cond[OSR_BIT_SYST] = syst_s; // RULE6
        op_if.cond[OSR_BIT_INST] = ap_if.summary; // RULE10
        op_if.cond[OSR_BIT_SCRIPT] = script_s; // RULE7
    end

    assign ap_if.cond = ap_live;
    assign op_if.wdata = REG_WDATA;
    assign ap_if.wdata = REG_WDATA;
    assign op_if.wr_enable = REG_WR && (REG_SEL == OSR_SEL_OP_ENABLE);
    assign op_if.wr_rise = REG_WR && (REG_SEL == OSR_SEL_OP_RISE);
    assign op_if.wr_fall = REG_WR && (REG_SEL == OSR_SEL_OP_FALL);
    assign ap_if.wr_enable = REG_WR && (REG_SEL == OSR_SEL_AP_ENABLE);
    assign ap_if.wr_rise = REG_WR && (REG_SEL == OSR_SEL_AP_RISE);
    assign ap_if.wr_fall = REG_WR && (REG_SEL == OSR_SEL_AP_FALL);
    assign op_if.clr_event = rd_op_event; // RULE12
    assign ap_if.clr_event = rd_ap_event; // RULE8

    ////////////////////////////////////////////////////////////////////////////
    // Apparatus condition register, cleared by its read
    logic [15:0] ap_cond_q;

    // A bit still true after the read is loaded again at once
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ap_cond_q <= OSR_RST_ZERO;
        end else if (rd_ap_cond) begin
            ap_cond_q <= ap_live; // RULE9
        end else begin
            ap_cond_q <= ap_cond_q | ap_live;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            REG_RDATA <= OSR_RST_ZERO;
        end else if (REG_RD) begin
            if (REG_SEL == OSR_SEL_OP_EVENT) begin
                REG_RDATA <= op_if.event_q; // RULE12
            end else if (REG_SEL == OSR_SEL_OP_COND) begin
                REG_RDATA <= op_if.cond; // RULE13
            end else if (REG_SEL == OSR_SEL_OP_ENABLE) begin
                REG_RDATA <= op_if.enable_q; // RULE5
            end else if (REG_SEL == OSR_SEL_OP_RISE) begin
                REG_RDATA <= op_if.rise_q; // RULE5
            end else if (REG_SEL == OSR_SEL_OP_FALL) begin
                REG_RDATA <= op_if.fall_q; // RULE5
            end else if (REG_SEL == OSR_SEL_AP_EVENT) begin
                REG_RDATA <= ap_if.event_q; // RULE8
            end else if (REG_SEL == OSR_SEL_AP_COND) begin
                REG_RDATA <= ap_cond_q; // RULE9
            end else if (REG_SEL == OSR_SEL_AP_ENABLE) begin
                REG_RDATA <= ap_if.enable_q; // RULE11
            end else if (REG_SEL == OSR_SEL_AP_RISE) begin
                REG_RDATA <= ap_if.rise_q; // RULE11
            end else if (REG_SEL == OSR_SEL_AP_FALL) begin
                REG_RDATA <= ap_if.fall_q; // RULE11
            end else begin
                REG_RDATA <= OSR_RST_ZERO;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
        end
    end

    assign OPER_SUMMARY = op_if.summary; // RULE1
    assign APPARATUS_SUMMARY = ap_if.summary; // RULE10

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    logic [15:0] op_prev_q;
    logic [15:0] ap_prev_q;
    logic [15:0] op_rise_hit;
    logic [15:0] ap_fall_hit;
    logic [15:0] op_hit;
    logic [15:0] ap_hit;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            op_prev_q <= OSR_RST_ZERO;
            ap_prev_q <= OSR_RST_ZERO;
        end else begin
            op_prev_q <= op_if.cond;
            ap_prev_q <= ap_if.cond;
        end
    end

    assign op_rise_hit = op_if.cond & ~op_prev_q & op_if.rise_q;
    assign ap_fall_hit = ~ap_if.cond & ap_prev_q & ap_if.fall_q;
    assign op_hit = op_rise_hit | (~op_if.cond & op_prev_q & op_if.fall_q);
    assign ap_hit = ap_fall_hit | (ap_if.cond & ~ap_prev_q & ap_if.rise_q);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_op_summary;
        @(posedge MCLK) disable iff (RESET)
        ((op_if.event_q & op_if.enable_q) != 16'h0000) |-> OPER_SUMMARY;
    endproperty
    a_op_summary: assert property (p_op_summary) // RULE1
        else $error("operation summary low with an enabled event");

    property p_write_range;
        @(posedge MCLK) disable iff (RESET)
        (REG_WR && REG_SEL == OSR_SEL_OP_ENABLE) |=>
            (op_if.enable_q == ($past(REG_WDATA) & OSR_WRITE_MASK));
    endproperty
    a_write_range: assert property (p_write_range) // RULE2
        else $error("enable mask write not stored within range");

    property p_rise_event;
        @(posedge MCLK) disable iff (RESET)
        (op_rise_hit != 16'h0000) |=>
            ((op_if.event_q & $past(op_rise_hit)) == $past(op_rise_hit));
    endproperty
    a_rise_event: assert property (p_rise_event) // RULE3
        else $error("rising condition did not set event bit");

    property p_fall_event;
        @(posedge MCLK) disable iff (RESET)
        (ap_fall_hit != 16'h0000) |=>
            ((ap_if.event_q & $past(ap_fall_hit)) == $past(ap_fall_hit));
    endproperty
    a_fall_event: assert property (p_fall_event) // RULE4
        else $error("falling condition did not set event bit");

    property p_op_rise_read;
        @(posedge MCLK) disable iff (RESET)
        (REG_RD && REG_SEL == OSR_SEL_OP_RISE) |=>
            (REG_RVALID && REG_RDATA == $past(op_if.rise_q));
    endproperty
    a_op_rise_read: assert property (p_op_rise_read) // RULE5
        else $error("operation rise filter readback wrong");

    property p_script_bit;
        @(posedge MCLK) disable iff (RESET)
        $rose(pin_s2_q[20]) |-> op_if.cond[OSR_BIT_SCRIPT] ##1
            (op_if.cond[OSR_BIT_SCRIPT] == pin_s2_q[20]);
    endproperty
    a_script_bit: assert property (p_script_bit) // RULE7
        else $error("script bit does not follow script activity");

    property p_ap_event_read;
        @(posedge MCLK) disable iff (RESET)
        rd_ap_event |=> (REG_RDATA == $past(ap_if.event_q))
            && (ap_if.event_q == $past(ap_hit));
    endproperty
    a_ap_event_read: assert property (p_ap_event_read) // RULE8
        else $error("apparatus event read did not return and clear");

    property p_ap_cond_read;
        @(posedge MCLK) disable iff (RESET)
        rd_ap_cond |=> (REG_RDATA == $past(ap_cond_q))
            && (ap_cond_q == $past(ap_live));
    endproperty
    a_ap_cond_read: assert property (p_ap_cond_read) // RULE9
        else $error("apparatus condition read did not return and clear");

    property p_ap_summary;
        @(posedge MCLK) disable iff (RESET)
        ((ap_if.event_q & ap_if.enable_q) != 16'h0000) |->
            (APPARATUS_SUMMARY && op_if.cond[OSR_BIT_INST]);
    endproperty
    a_ap_summary: assert property (p_ap_summary) // RULE10
        else $error("apparatus summary not reaching operation bit 13");

    property p_ap_fall_read;
        @(posedge MCLK) disable iff (RESET)
        (REG_RD && REG_SEL == OSR_SEL_AP_FALL) |=>
            (REG_RDATA == $past(ap_if.fall_q));
    endproperty
    a_ap_fall_read: assert property (p_ap_fall_read) // RULE11
        else $error("apparatus fall filter readback wrong");

    property p_op_event_read;
        @(posedge MCLK) disable iff (RESET)
        rd_op_event |=> (REG_RDATA == $past(op_if.event_q))
            && (op_if.event_q == $past(op_hit));
    endproperty
    a_op_event_read: assert property (p_op_event_read) // RULE12
        else $error("operation event read did not return and clear");

    property p_op_cond_read;
        @(posedge MCLK) disable iff (RESET)
        (REG_RD && REG_SEL == OSR_SEL_OP_COND) |=>
            (REG_RDATA == $past(op_if.cond)) && $stable(op_if.enable_q)
            && ((op_if.event_q & $past(op_if.event_q)) == $past(op_if.event_q));
    endproperty
    a_op_cond_read: assert property (p_op_cond_read) // RULE13
        else $error("operation condition read was destructive");

    property p_event_hold;
        @(posedge MCLK) disable iff (RESET)
        !rd_op_event |=>
            ((op_if.event_q & $past(op_if.event_q)) == $past(op_if.event_q));
    endproperty
    a_event_hold: assert property (p_event_hold) // RULE14
        else $error("operation event bit dropped without a read");

    property p_cal_bit;
        @(posedge MCLK) disable iff (RESET)
        $rose(CALIBRATING_FLAG) |-> ##2 op_if.cond[OSR_BIT_CAL];
    endproperty
    a_cal_bit: assert property (p_cal_bit) // RULE6
        else $error("calibration bit not in position 0 two cycles after pin");

endmodule // osr_top

// *** tb/osr_top_test.sv ***
// Self-checking testbench for the operation status register set
`timescale 1ns/100ps

module osr_top_test;
    import osr_pkg::*;

    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic CALIBRATING_FLAG = 1'b0;
    logic SWEEPING_FLAG = 1'b0;
    logic TRIGGER_SUMMARY_FLAG = 1'b0;
    logic SYSTEM_SUMMARY_FLAG = 1'b0;
    logic SCRIPT_ACTIVE_FLAG = 1'b0;
    logic [15:0] APPARATUS_COND = 16'h0000;
    logic [3:0] REG_SEL = 4'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic [15:0] REG_RDATA;
    logic REG_RVALID;
    logic OPER_SUMMARY;
    logic APPARATUS_SUMMARY;
    int fails = 0;
    int samples_checked = 0;
    logic [15:0] op_en = 16'h0000, op_ri = 16'h7FFF, op_fa = 16'h0000;
    logic [15:0] ap_en = 16'h0000, ap_ri = 16'h7FFF, ap_fa = 16'h0000;
    logic [15:0] op_ev = 16'h0000, op_prev = 16'h0000;
    logic [15:0] ap_ev = 16'h0000, ap_prev = 16'h0000, ap_lat = 16'h0000;
    logic [15:0] got, want;
    logic [3:0] wsel [6] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
    int unsigned r;

    always #25 MCLK = ~MCLK;

    osr_top uut (
        .MCLK(MCLK),
        .RESET(RESET),
        .CALIBRATING_FLAG(CALIBRATING_FLAG),
        .SWEEPING_FLAG(SWEEPING_FLAG),
        .TRIGGER_SUMMARY_FLAG(TRIGGER_SUMMARY_FLAG),
        .SYSTEM_SUMMARY_FLAG(SYSTEM_SUMMARY_FLAG),
        .SCRIPT_ACTIVE_FLAG(SCRIPT_ACTIVE_FLAG),
        .APPARATUS_COND(APPARATUS_COND),
        .REG_SEL(REG_SEL),
        .REG_WR(REG_WR),
        .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID),
        .OPER_SUMMARY(OPER_SUMMARY),
        .APPARATUS_SUMMARY(APPARATUS_SUMMARY)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp_v, input string what);
        samples_checked++;
        if (seen !== exp_v) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp_v);
        end
    endtask

    task summarize();
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Live operation condition word as the model sees it
    function automatic logic [15:0] op_cond();
        logic [15:0] c;
        c = 16'h0000;
        c[0] = CALIBRATING_FLAG;
        c[3] = SWEEPING_FLAG;
        c[5] = TRIGGER_SUMMARY_FLAG;
        c[12] = SYSTEM_SUMMARY_FLAG;
        c[13] = |(ap_ev & ap_en);
        c[14] = SCRIPT_ACTIVE_FLAG;
        return c;
    endfunction

    // Lets the synchronisers and the cascade settle, then advances the model
    task settle();
        logic [15:0] c;
        repeat (8) @(negedge MCLK);
        ap_ev |= (APPARATUS_COND & ~ap_prev & ap_ri) | (~APPARATUS_COND & ap_prev & ap_fa);
        ap_lat |= APPARATUS_COND;
        ap_prev = APPARATUS_COND;
        c = op_cond();
        op_ev |= (c & ~op_prev & op_ri) | (~c & op_prev & op_fa);
        op_prev = c;
        check({15'h0000, OPER_SUMMARY}, {15'h0000, |(op_ev & op_en)}, "op summary");
        check({15'h0000, APPARATUS_SUMMARY}, {15'h0000, |(ap_ev & ap_en)}, "ap summary");
    endtask

    task reg_wr(input logic [3:0] sel, input logic [15:0] data);
        REG_SEL = sel;
        REG_WDATA = data;
        REG_WR = 1'b1;
        @(negedge MCLK);
        REG_WR = 1'b0;
        case (sel)
            OSR_SEL_OP_ENABLE: op_en = data & 16'h7FFF;
            OSR_SEL_OP_RISE: op_ri = data & 16'h7FFF;
            OSR_SEL_OP_FALL: op_fa = data & 16'h7FFF;
            OSR_SEL_AP_ENABLE: ap_en = data & 16'h7FFF;
            OSR_SEL_AP_RISE: ap_ri = data & 16'h7FFF;
            OSR_SEL_AP_FALL: ap_fa = data & 16'h7FFF;
            default: ;
        endcase
        settle();
    endtask

    task reg_rd(input logic [3:0] sel, output logic [15:0] seen, output logic [15:0] exp_v);
        REG_SEL = sel;
        REG_RD = 1'b1;
        @(negedge MCLK);
        REG_RD = 1'b0;
        seen = REG_RDATA;
        check({15'h0000, REG_RVALID}, 16'h0001, "read valid missing");
        @(negedge MCLK);
        check({15'h0000, REG_RVALID}, 16'h0000, "read valid too long");
        case (sel)
            OSR_SEL_OP_EVENT: begin
                exp_v = op_ev;
                op_ev = 16'h0000;
            end
            OSR_SEL_OP_COND: exp_v = op_cond();
            OSR_SEL_OP_ENABLE: exp_v = op_en;
            OSR_SEL_OP_RISE: exp_v = op_ri;
            OSR_SEL_OP_FALL: exp_v = op_fa;
            OSR_SEL_AP_EVENT: begin
                exp_v = ap_ev;
                ap_ev = 16'h0000;
            end
            OSR_SEL_AP_COND: begin
                exp_v = ap_lat;
                ap_lat = APPARATUS_COND;
            end
            OSR_SEL_AP_ENABLE: exp_v = ap_en;
            OSR_SEL_AP_RISE: exp_v = ap_ri;
            OSR_SEL_AP_FALL: exp_v = ap_fa;
            default: exp_v = 16'h0000;
        endcase
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        fails++;
        summarize();
    end

    initial begin
        r = $urandom(25);
        repeat (3) @(negedge MCLK);
        RESET = 1'b0;
        settle();
        for (int s = 0; s < 16; s++) begin
            reg_rd(4'(s), got, want);
            check(got, want, "reset value");
        end
        // Bit 15 never sticks, then random values read back unchanged
        for (int k = 0; k < 6; k++) begin
            reg_wr(wsel[k], 16'hFFFF);
            reg_rd(wsel[k], got, want);
            check(got, 16'h7FFF, "write range");
        end
        for (int k = 0; k < 3; k++) begin
            r = $urandom();
            reg_wr(wsel[k], r[15:0]);
            reg_rd(wsel[k], got, want);
            check(got, want, "op readback");
            reg_wr(wsel[k + 3], r[31:16]);
            reg_rd(wsel[k + 3], got, want);
            check(got, want, "ap readback");
        end
        for (int k = 0; k < 6; k++) begin
            reg_wr(wsel[k], 16'h0000);
        end
        reg_rd(OSR_SEL_OP_EVENT, got, want);
        reg_rd(OSR_SEL_AP_EVENT, got, want);
        ////////////////////////////////////////////////////////////////////////////////
        reg_wr(OSR_SEL_OP_RISE, 16'h0008);
        reg_wr(OSR_SEL_OP_FALL, 16'h0001);
        reg_wr(OSR_SEL_OP_ENABLE, 16'h0009);
        SWEEPING_FLAG = 1'b1;
        CALIBRATING_FLAG = 1'b1;
        settle();
        SWEEPING_FLAG = 1'b0;
        CALIBRATING_FLAG = 1'b0;
        settle();
        reg_rd(OSR_SEL_OP_EVENT, got, want);
        check(got & 16'h0008, 16'h0008, "rise event");
        check(got & 16'h0001, 16'h0001, "fall event");
        check(got, want, "sticky events");
        reg_rd(OSR_SEL_OP_EVENT, got, want);
        check(got, 16'h0000, "event cleared");
        {CALIBRATING_FLAG, SWEEPING_FLAG, TRIGGER_SUMMARY_FLAG, SYSTEM_SUMMARY_FLAG,
            SCRIPT_ACTIVE_FLAG} = 5'h1F;
        settle();
        reg_rd(OSR_SEL_OP_COND, got, want);
        check(got, 16'h5029, "condition map");
        reg_rd(OSR_SEL_OP_COND, got, want);
        check(got, want, "condition reread");
        SCRIPT_ACTIVE_FLAG = 1'b0;
        settle();
        reg_rd(OSR_SEL_OP_COND, got, want);
        check(got, 16'h1029, "script idle");
        ////////////////////////////////////////////////////////////////////////////////
        reg_wr(OSR_SEL_AP_RISE, 16'h00FF);
        reg_wr(OSR_SEL_AP_FALL, 16'hFF00);
        reg_wr(OSR_SEL_AP_ENABLE, 16'h0001);
        reg_wr(OSR_SEL_OP_RISE, 16'h2000);
        reg_wr(OSR_SEL_OP_ENABLE, 16'h2000);
        APPARATUS_COND = 16'h0101;
        settle();
        APPARATUS_COND = 16'h0001;
        settle();
        reg_rd(OSR_SEL_OP_EVENT, got, want);
        check(got & 16'h2000, 16'h2000, "nested summary event");
        reg_rd(OSR_SEL_AP_EVENT, got, want);
        check(got, 16'h0101, "ap events");
        reg_rd(OSR_SEL_AP_EVENT, got, want);
        check(got, 16'h0000, "ap event cleared");
        reg_rd(OSR_SEL_AP_COND, got, want);
        check(got, 16'h0101, "ap condition");
        reg_rd(OSR_SEL_AP_COND, got, want);
        check(got, 16'h0001, "ap condition reloaded");
        ////////////////////////////////////////////////////////////////////////////////
        for (int i = 0; i < 150; i++) begin
            r = $urandom();
            case (r[1:0])
                2'h0: begin
                    {CALIBRATING_FLAG, SWEEPING_FLAG, TRIGGER_SUMMARY_FLAG,
                        SYSTEM_SUMMARY_FLAG, SCRIPT_ACTIVE_FLAG} = r[6:2];
                    APPARATUS_COND = r[31:16];
                    settle();
                end
                2'h1: reg_wr(wsel[r[4:2] % 6], r[31:16]);
                default: begin
                    reg_rd(r[5:2], got, want);
                    check(got, want, "random read");
                end
            endcase
        end
        summarize();
    end
endmodule // osr_top_test
